/* File: pkg/hdr_xlate_pkg.sv */
// shared constants and carriers for the inlet header translation block
package hdr_xlate_pkg;
	// register offsets
	localparam logic [3:0]  REG_CTRL      = 4'h0;
	localparam logic [3:0]  REG_MISS      = 4'h4;
	localparam logic [3:0]  REG_STAT      = 4'h8;
	localparam logic [7:0]  CTRL_RESET    = 8'h00;
	// control register bit positions
	localparam int          CTL_USER_SIDE = 0;
	localparam int          CTL_ROUTE_EN  = 1;
	localparam int          CTL_SECOND    = 2;
	localparam int          CTL_RPP_LO    = 3;
	localparam int          CTL_IGN_OVR   = 5;
	// record byte 0 flag positions
	localparam int          FLG_ACTIVE    = 7;
	localparam int          FLG_VP_ONLY   = 6;
	localparam int          FLG_SPECIAL   = 5;
	localparam int          FLG_IGNORE    = 4;
	localparam int          MODE_LO       = 5;
	localparam logic [1:0]  MODE_RECORD   = 2'h0;
	localparam logic [1:0]  MODE_ORDINARY = 2'h1;
	localparam logic [1:0]  MODE_KEEP     = 2'h2;
	// log2 of records per page, indexed by the select code
	localparam logic [3:0][3:0] RPP_SHIFT = {4'h7, 4'hA, 4'h9, 4'h8};
	// record geometry
	localparam logic [17:0] VP_CNT_USER   = 18'h0_0100;
	localparam logic [17:0] VP_CNT_NET    = 18'h0_1000;
	localparam logic [3:0]  VP_SZ_PLAIN   = 4'h4;
	localparam logic [3:0]  VP_SZ_SECOND  = 4'h6;
	localparam logic [3:0]  VC_SZ_PLAIN   = 4'h6;
	localparam logic [3:0]  VC_SZ_SECOND  = 4'h8;
	localparam logic [8:0]  MAX_PAGES     = 9'h100;
	localparam logic [4:0]  PAGE_CODE_FULL = 5'h10;
	// special cell records in page zero
	localparam logic [15:0] SPECIAL_SPAN  = 16'h0020;
	localparam logic [15:0] VCI_SEG_OAM   = 16'h0006;
	localparam logic [2:0]  PT_SEG_OAM    = 3'h6;
	localparam logic [5:0]  REC_VC6       = 6'h20;
	localparam logic [5:0]  REC_PT_BASE   = 6'h21;
	// bus answers
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_FETCH = 4'b0010,
		ST_DEC   = 4'b0100,
		ST_OUT   = 4'b1000
	} state_e;

	typedef enum logic [2:0] {
		KIND_VP = 3'b001,
		KIND_VC = 3'b010,
		KIND_SP = 3'b100
	} kind_e;

	typedef struct packed {
		logic [11:0] vpi;
		logic [15:0] vci;
		logic [2:0]  pt;
		logic        clp;
	} cell_in_s;

	typedef struct packed {
		logic [11:0] vpi;
		logic [15:0] vci;
		logic [2:0]  pt;
		logic        clp;
		logic [15:0] bus_hdr;
		logic [15:0] second_hdr;
		logic        second_en;
		logic        hdr_added;
	} cell_out_s;
endpackage

/* File: rtl/tram_reader.sv */
// byte-wide pipelined reader for the external translation memory
module tram_reader (
	// clock and reset
	input  logic        clk,
	input  logic        rst_n,
	// request
	input  logic        start,
	input  logic [17:0] base,
	input  logic [3:0]  len,
	// memory pins
	output logic [17:0] tram_addr,
	output logic        tram_oe_n,
	input  logic [7:0]  tram_data,
	// returned bytes
	output logic        byte_v,
	output logic [2:0]  byte_idx,
	output logic [7:0]  byte_data,
	output logic        done
);
	typedef struct packed {
		logic [17:0] addr;
		logic        oe_n;
		logic [3:0]  left;
		logic [2:0]  iss_idx;
		logic [1:0]  vpipe;
		logic [2:0]  idx0;
		logic [2:0]  idx1;
		logic        last0;
		logic        last1;
		logic [7:0]  sync1;
		logic [7:0]  sync2;
		logic        bv;
		logic [2:0]  bidx;
		logic        done;
	} rd_s;

	rd_s s;
	rd_s n;

	// memory data is asynchronous to us: two flops before use
	always_comb begin
		n = s;
		n.sync1 = tram_data;
		n.sync2 = s.sync1;
		n.idx1 = s.idx0;
		n.last1 = s.last0;
		n.bv = s.vpipe[1];
		n.bidx = s.idx1;
		n.done = s.vpipe[1] && s.last1;
		n.vpipe = {s.vpipe[0], 1'b0};
		n.last0 = 1'b0;
		if (start && s.left == 4'h0) begin
			n.addr = base;
			n.left = len - 4'h1;
			n.vpipe[0] = 1'b1;
			n.idx0 = 3'h0;
			n.last0 = (len == 4'h1);
			n.iss_idx = 3'h1;
		end else if (s.left != 4'h0) begin
			n.addr = s.addr + 18'h0_0001;
			n.left = s.left - 4'h1;
			n.vpipe[0] = 1'b1;
			n.idx0 = s.iss_idx;
			n.last0 = (s.left == 4'h1);
			n.iss_idx = s.iss_idx + 3'h1;
		end
		// keep the memory enabled until the last byte is sampled
		n.oe_n = !(n.vpipe[0] || s.vpipe[0]);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.oe_n <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign tram_addr = s.addr;
	assign tram_oe_n = s.oe_n;
	assign byte_v = s.bv;
	assign byte_idx = s.bidx;
	assign byte_data = s.sync2;
	assign done = s.done;
endmodule

/* File: rtl/hdr_xlate.sv */
// inlet header translation engine with external record memory
// Function
// (R01) select 00/01/10/11 gives 256/512/1024/128 records per page
// (R02) never address a page index of 256 or above
// (R03) special page-zero routing only while route enable bit 1 is set
// (R04) full incoming VPI, 8 or 12 bits, indexes the VPI record
// (R05) low nibble of byte 0 is page count, 0 means 16; byte 1 first page
// (R06) a VPI's pages span consecutive VCIs from zero; VCI picks its record
// (R07) every record carries active, VPI-only, special, ignore flags in byte 0; special records use bits 6:5 as the mode instead
// (R08) active and not ignored forwards; inactive and not ignored counts as misrouted
// (R09) VPI-only flag set translates VPI alone, clear does two-step lookup
// (R10) special flag in VPI record routes VCI 0..31 via page-zero records 0..31
// (R11) special flag in VPI record routes VCI 6 with PT 110 via record 32
// (R12) special flag in VCI record routes PT 100..111 via records 33..36
// (R13) other cells use their ordinary VP or VC record
// (R14) active with ignore set discards without counting
// (R15) ignore override bit 5 treats ignore flags as clear
// (R16) mode 00 special record, 01 ordinary record, 10 keep ids, 11 reserved
// (R17) second header only inserted when its enable bit is set
// (R18) bus routing header is sixteen bits from the record
// (R19) VPI record is 4 or 6 bytes at VPI times 4 or 6
// (R20) VPI-only: new VPI from byte 0 nibble and byte 1, headers follow
// (R21) VCI record is 6 or 8 bytes holding new VPI, VCI and headers
// (R22) translate only while translate pin is low, else pass untouched
// (R23) VPI block of 256 or 4096 records sits at memory bottom
// (R24) VC address is block size plus page and VCI offsets times record size
// (R25) byte-wide reads over 18-bit address finish before the cell leaves
// (R26) misrouted counter increments once per inactive, non-ignored discard
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
module hdr_xlate (
	// clock and reset
	input  logic                    clk,
	input  logic                    rst_n,
	// register bus
	input  logic [3:0]              awaddr,
	input  logic                    awvalid,
	output logic                    awready,
	input  logic [31:0]             wdata,
	input  logic [3:0]              wstrb,
	input  logic                    wvalid,
	output logic                    wready,
	output logic [1:0]              bresp,
	output logic                    bvalid,
	input  logic                    bready,
	input  logic [3:0]              araddr,
	input  logic                    arvalid,
	output logic                    arready,
	output logic [31:0]             rdata,
	output logic [1:0]              rresp,
	output logic                    rvalid,
	input  logic                    rready,
	// incoming cell headers
	input  hdr_xlate_pkg::cell_in_s  cell_in,
	input  logic                    cell_valid,
	output logic                    cell_ready,
	// translated cell headers
	output hdr_xlate_pkg::cell_out_s cell_out,
	output logic                    out_valid,
	input  logic                    out_ready,
	// translate pin, low to translate
	input  logic                    translate_n,
	// record memory
	output logic [17:0]             tram_addr,
	output logic                    tram_oe_n,
	input  logic [7:0]              tram_data
);
	import hdr_xlate_pkg::*;

	typedef struct packed {
		state_e      st;
		kind_e       kind;
		logic [7:0]  ctrl;
		logic        tsync1;
		logic        tsync2;
		cell_in_s    cur;
		logic [7:0][7:0] rec;
		logic [3:0]  pg_cnt;
		logic [7:0]  pg_base;
		logic        ord_ok;
		logic [11:0] o_vpi;
		logic [15:0] o_vci;
		logic [15:0] o_bus;
		logic [15:0] o_sec;
		logic        go;
		logic [17:0] base;
		logic [3:0]  len;
		logic        cell_rdy;
		cell_out_s   out;
		logic        out_v;
		logic        bypass;
		logic [31:0] miss;
		logic        aw_got;
		logic        w_got;
		logic [3:0]  awa;
		logic [7:0]  wd;
		logic        wlane;
		logic        awrdy;
		logic        wrdy;
		logic        bv;
		logic [1:0]  br;
		logic        arrdy;
		logic        rv;
		logic [31:0] rd;
		logic [1:0]  rr;
	} top_s;

	top_s s;
	top_s n;

	logic        byte_v;
	logic [2:0]  byte_idx;
	logic [7:0]  byte_data;
	logic        fetch_done;
	logic        miss_now;

	function automatic logic [17:0] rec_addr(logic [17:0] blk, logic [23:0] idx,
		logic [3:0] sz);
		logic [27:0] p;
		p = idx * sz;
		return blk + p[17:0];
	endfunction

	// returns {in span, record address}
	function automatic logic [18:0] vc_lookup(logic [15:0] vci, logic [3:0] code,
		logic [7:0] pbase, logic [3:0] shift, logic [17:0] blk, logic [3:0] sz);
		logic [15:0] page;
		logic [4:0]  cnt;
		logic [8:0]  absp;
		logic [23:0] idx;
		page = vci >> shift;
		cnt = (code == 4'h0) ? PAGE_CODE_FULL : {1'b0, code}; // [R05]
		absp = {1'b0, pbase} + page[8:0];
		idx = ({16'h0000, pbase} << shift) + {8'h00, vci}; // [R06]
		return {(page < {11'h000, cnt}) && (absp < MAX_PAGES), // [R02]
			rec_addr(blk, idx, sz)}; // [R24]
	endfunction

	function automatic cell_out_s make_out(cell_in_s c, logic [11:0] vpi,
		logic [15:0] vci, logic [15:0] bus, logic [15:0] sec, logic sec_en, logic added);
		cell_out_s o;
		o.vpi = vpi;
		o.vci = vci;
		o.pt = c.pt;
		o.clp = c.clp;
		o.bus_hdr = bus;
		o.second_hdr = sec_en ? sec : 16'h0000; // [R17]
		o.second_en = sec_en;
		o.hdr_added = added;
		return o;
	endfunction

	// configuration and record fields
	logic        user_side;
	logic        route_en;
	logic        second_en;
	logic        ign_ovr;
	logic [3:0]  shift;
	logic [3:0]  vp_sz;
	logic [3:0]  vc_sz;
	logic [17:0] vp_blk;
	logic [11:0] vpi_idx;
	logic [7:0]  b0;
	logic        act;
	logic        ign_eff;
	logic [1:0]  sp_mode;
	logic [11:0] rv_vpi;
	logic [15:0] rv_vci;
	logic [15:0] rv_bus;
	logic [15:0] rv_sec;
	logic [15:0] vp_bus;
	logic [15:0] vp_sec;
	logic        sp_vp;
	logic [5:0]  sp_vp_idx;
	logic        sp_vc;
	logic [5:0]  sp_vc_idx;
	logic        vc_ok;
	logic [17:0] vc_addr;

	assign user_side = s.ctrl[CTL_USER_SIDE];
	assign route_en = s.ctrl[CTL_ROUTE_EN];
	assign second_en = s.ctrl[CTL_SECOND];
	assign ign_ovr = s.ctrl[CTL_IGN_OVR];
	assign shift = RPP_SHIFT[s.ctrl[CTL_RPP_LO+:2]]; // [R01]
	assign vp_sz = second_en ? VP_SZ_SECOND : VP_SZ_PLAIN; // [R19]
	assign vc_sz = second_en ? VC_SZ_SECOND : VC_SZ_PLAIN; // [R21]
	assign vp_blk = rec_addr(18'h0_0000, {6'h00, user_side ? VP_CNT_USER : VP_CNT_NET},
		vp_sz); // [R23]
	assign vpi_idx = user_side ? {4'h0, cell_in.vpi[7:0]} : cell_in.vpi; // [R04]
	assign b0 = s.rec[0];
	assign act = b0[FLG_ACTIVE]; // [R07]
	assign ign_eff = b0[FLG_IGNORE] && !ign_ovr; // [R15]
	assign sp_mode = b0[MODE_LO+:2];
	assign rv_vpi = {b0[3:0], s.rec[1]}; // [R20]
	assign rv_vci = {s.rec[2], s.rec[3]};
	assign rv_bus = {s.rec[4], s.rec[5]}; // [R18]
	assign rv_sec = {s.rec[6], s.rec[7]};
	assign vp_bus = {s.rec[2], s.rec[3]};
	assign vp_sec = {s.rec[4], s.rec[5]};
	assign sp_vp = b0[FLG_SPECIAL] && route_en && (s.cur.vci < SPECIAL_SPAN); // [R03] [R10]
	assign sp_vp_idx = (s.cur.vci == VCI_SEG_OAM && s.cur.pt == PT_SEG_OAM) ?
		REC_VC6 : s.cur.vci[5:0]; // [R11]
	assign sp_vc = b0[FLG_SPECIAL] && route_en && s.cur.pt[2]; // [R12]
	assign sp_vc_idx = REC_PT_BASE + {4'h0, s.cur.pt[1:0]};
	// page data comes from the fresh VPI record or from the copy kept for it
	assign {vc_ok, vc_addr} = vc_lookup(s.cur.vci,
		(s.kind == KIND_VP) ? b0[3:0] : s.pg_cnt,
		(s.kind == KIND_VP) ? s.rec[1] : s.pg_base, shift, vp_blk, vc_sz);

	always_comb begin
		n = s;
		miss_now = 1'b0;
		n.go = 1'b0;
		n.tsync1 = translate_n;
		n.tsync2 = s.tsync1;
		// write channel: address and data taken in either order
		if (awvalid && s.awrdy) begin
			n.awrdy = 1'b0;
			n.aw_got = 1'b1;
			n.awa = awaddr;
		end
		if (wvalid && s.wrdy) begin
			n.wrdy = 1'b0;
			n.w_got = 1'b1;
			n.wd = wdata[7:0];
			n.wlane = wstrb[0];
		end
		if (s.aw_got && s.w_got && !s.bv) begin
			n.bv = 1'b1;
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.br = RESP_OKAY;
			if ({s.awa[3:2], 2'h0} == REG_CTRL) begin
				if (s.wlane) begin
					n.ctrl = s.wd;
				end
			end else if ({s.awa[3:2], 2'h0} != REG_MISS && {s.awa[3:2], 2'h0} != REG_STAT) begin
				n.br = RESP_SLVERR;
			end
		end
		if (s.bv && bready) begin
			n.bv = 1'b0;
			n.awrdy = 1'b1;
			n.wrdy = 1'b1;
		end
		// read channel
		if (arvalid && s.arrdy) begin
			n.arrdy = 1'b0;
			n.rv = 1'b1;
			n.rr = RESP_OKAY;
			if ({araddr[3:2], 2'h0} == REG_CTRL) begin
				n.rd = {24'h00_0000, s.ctrl};
			end else if ({araddr[3:2], 2'h0} == REG_MISS) begin
				n.rd = s.miss;
			end else if ({araddr[3:2], 2'h0} == REG_STAT) begin
				n.rd = {29'h0000_0000, s.out_v, !s.tsync2, s.st != ST_IDLE};
			end else begin
				n.rd = 32'h0000_0000;
				n.rr = RESP_SLVERR;
			end
		end
		if (s.rv && rready) begin
			n.rv = 1'b0;
			n.arrdy = 1'b1;
		end
		// translation engine
		case (s.st)
			ST_IDLE: begin
				if (!s.cell_rdy) begin
					n.cell_rdy = 1'b1;
				end else if (cell_valid) begin
					n.cell_rdy = 1'b0;
					n.cur = cell_in;
					n.ord_ok = 1'b0;
					if (s.tsync2) begin
						n.out = make_out(cell_in, cell_in.vpi, cell_in.vci, 16'h0000,
							16'h0000, 1'b0, 1'b0); // [R22]
						n.out_v = 1'b1;
						n.bypass = 1'b1;
						n.st = ST_OUT;
					end else begin
						n.bypass = 1'b0;
						n.go = 1'b1;
						n.base = rec_addr(18'h0_0000, {12'h000, vpi_idx}, vp_sz); // [R04] [R19]
						n.len = vp_sz;
						n.kind = KIND_VP;
						n.st = ST_FETCH;
					end
				end
			end
			ST_FETCH: begin
				if (byte_v) begin
					n.rec[byte_idx] = byte_data; // [R25]
				end
				if (fetch_done) begin
					n.st = ST_DEC;
				end
			end
			ST_DEC: begin
				n.st = ST_IDLE;
				if (ign_eff) begin
					// dropped silently, counter untouched [R14]
				end else if (!act) begin
					miss_now = 1'b1; // [R08]
				end else begin
					case (s.kind)
						KIND_VP: begin
							n.pg_cnt = b0[3:0]; // [R05]
							n.pg_base = s.rec[1];
							if (b0[FLG_VP_ONLY]) begin
								n.ord_ok = 1'b1;
								n.o_vpi = rv_vpi;
								n.o_vci = s.cur.vci;
								n.o_bus = vp_bus;
								n.o_sec = vp_sec;
							end
							if (sp_vp) begin
								n.go = 1'b1; // [R10] [R11]
								n.base = rec_addr(vp_blk, {18'h0_0000, sp_vp_idx}, vc_sz);
								n.len = vc_sz;
								n.kind = KIND_SP;
								n.st = ST_FETCH;
							end else if (b0[FLG_VP_ONLY]) begin
								n.out = make_out(s.cur, rv_vpi, s.cur.vci, vp_bus, vp_sec,
									second_en, 1'b1); // [R09] [R13] [R20]
								n.out_v = 1'b1;
								n.st = ST_OUT;
							end else if (vc_ok) begin
								n.go = 1'b1; // [R09] [R24]
								n.base = vc_addr;
								n.len = vc_sz;
								n.kind = KIND_VC;
								n.st = ST_FETCH;
							end else begin
								// VCI beyond the assigned pages is treated as misrouted
								miss_now = 1'b1;
							end
						end
						KIND_VC: begin
							n.ord_ok = 1'b1;
							n.o_vpi = rv_vpi;
							n.o_vci = rv_vci;
							n.o_bus = rv_bus;
							n.o_sec = rv_sec;
							if (sp_vc) begin
								n.go = 1'b1; // [R12]
								n.base = rec_addr(vp_blk, {18'h0_0000, sp_vc_idx}, vc_sz);
								n.len = vc_sz;
								n.kind = KIND_SP;
								n.st = ST_FETCH;
							end else begin
								n.out = make_out(s.cur, rv_vpi, rv_vci, rv_bus, rv_sec,
									second_en, 1'b1); // [R13] [R21]
								n.out_v = 1'b1;
								n.st = ST_OUT;
							end
						end
						default: begin
							if (sp_mode == MODE_RECORD) begin
								n.out = make_out(s.cur, rv_vpi, rv_vci, rv_bus, rv_sec,
									second_en, 1'b1); // [R16]
								n.out_v = 1'b1;
								n.st = ST_OUT;
							end else if (sp_mode == MODE_KEEP) begin
								n.out = make_out(s.cur, s.cur.vpi, s.cur.vci, rv_bus, rv_sec,
									second_en, 1'b1); // [R16]
								n.out_v = 1'b1;
								n.st = ST_OUT;
							end else if (sp_mode == MODE_ORDINARY && s.ord_ok) begin
								n.out = make_out(s.cur, s.o_vpi, s.o_vci, s.o_bus, s.o_sec,
									second_en, 1'b1); // [R16]
								n.out_v = 1'b1;
								n.st = ST_OUT;
							end else if (sp_mode == MODE_ORDINARY && vc_ok) begin
								// F4 cell on a two-step VPI: its ordinary record is the VC one
								n.go = 1'b1;
								n.base = vc_addr;
								n.len = vc_sz;
								n.kind = KIND_VC;
								n.st = ST_FETCH;
							end
						end
					endcase
				end
				if (miss_now) begin
					n.miss = s.miss + 32'h0000_0001; // [R26]
				end
			end
			default: begin
				if (out_ready) begin
					n.out_v = 1'b0;
					n.st = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.kind <= KIND_VP;
			s.ctrl <= CTRL_RESET; // [R03]
			s.tsync1 <= 1'b1;
			s.tsync2 <= 1'b1;
			s.awrdy <= 1'b1;
			s.wrdy <= 1'b1;
			s.arrdy <= 1'b1;
		end else begin
			s <= n;
		end
	end

	tram_reader u_reader (
		.clk       (clk),
		.rst_n     (rst_n),
		.start     (s.go),
		.base      (s.base),
		.len       (s.len),
		.tram_addr (tram_addr),
		.tram_oe_n (tram_oe_n),
		.tram_data (tram_data),
		.byte_v    (byte_v),
		.byte_idx  (byte_idx),
		.byte_data (byte_data),
		.done      (fetch_done)
	);

	assign awready = s.awrdy;
	assign wready = s.wrdy;
	assign bvalid = s.bv;
	assign bresp = s.br;
	assign arready = s.arrdy;
	assign rvalid = s.rv;
	assign rdata = s.rd;
	assign rresp = s.rr;
	assign cell_ready = s.cell_rdy;
	assign cell_out = s.out;
	assign out_valid = s.out_v;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence seq_fetch_start;
		s.go ##1 (s.st == ST_FETCH) [*2];
	endsequence

	chk_vp_index: assert property (s.go && s.kind == KIND_VP |-> // [R19]
		s.base == 18'({6'h00, $past(vpi_idx)} * vp_sz) && s.base < vp_blk)
		else $error("VPI record address wrong");
	chk_special_gate: assert property (s.go && s.kind == KIND_SP |-> // [R03]
		route_en && s.base >= vp_blk)
		else $error("special record fetched while routing disabled");
	chk_vc_span: assert property (s.go && s.kind == KIND_VC |-> $past(vc_ok)) // [R06]
		else $error("VC record fetched outside assigned pages");
	chk_miss_count: assert property (s.miss != $past(s.miss) |-> // [R26]
		$past(miss_now) && s.miss == $past(s.miss) + 32'h0000_0001)
		else $error("misrouted count moved without cause");
	chk_ignored_uncounted: assert property (s.st == ST_DEC && act && ign_eff |=> // [R14]
		s.miss == $past(s.miss) && s.st == ST_IDLE && !s.out_v)
		else $error("ignored cell counted or forwarded");
	chk_pass_through: assert property ($rose(s.out_v) && s.bypass |-> // [R22]
		!s.out.hdr_added && s.out.vpi == s.cur.vpi && s.out.vci == s.cur.vci)
		else $error("bypassed cell altered");
	chk_second_hdr: assert property (s.out_v && s.out.second_hdr != 16'h0000 |-> // [R17]
		s.out.second_en)
		else $error("second header without enable");
	chk_keep_ids: assert property (s.st == ST_DEC && s.kind == KIND_SP && act && // [R16]
		!ign_eff && sp_mode == MODE_KEEP |=> s.out_v && s.out.vpi == $past(s.cur.vpi)
		&& s.out.bus_hdr == $past(rv_bus))
		else $error("keep mode changed identifiers");
	chk_fetch_done: assert property (seq_fetch_start |-> ##[1:16] fetch_done) // [R25]
		else $error("record fetch did not finish");
endmodule

/* File: verif/tram_model.sv */
// byte-wide record memory standing at the far side of the translation engine
module tram_model (
	// memory pins
	input  logic [17:0] tram_addr,
	input  logic        tram_oe_n,
	output logic [7:0]  tram_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:262143];
	initial begin
		tram_data = 8'h00;
		foreach (mem[i]) begin
			mem[i] = 8'h00;
		end
	end
	// released bus shows the inverted last byte, so a late sample never matches by luck
	always @(tram_addr, tram_oe_n) begin
		#10 tram_data = tram_oe_n ? ~tram_data : mem[tram_addr];
	end
endmodule

/* File: verif/tb.sv */
// self-checking bench for the inlet header translation engine
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import hdr_xlate_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  awaddr = 4'h0;
	logic [3:0]  araddr = 4'h0;
	logic [3:0]  wstrb = 4'hF;
	logic [31:0] wdata = 32'h0000_0000;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        cell_valid = 1'b0, out_ready = 1'b1, translate_n = 1'b1;
	logic        awready, wready, bvalid, arready, rvalid, cell_ready, out_valid, tram_oe_n;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [17:0] tram_addr;
	logic [7:0]  tram_data;
	cell_in_s    cell_in = '0;
	cell_out_s   cell_out;
	int          n_fail = 0;
	int          tests_run = 0;
	// expected {second_en, second_hdr} of forwarded cells
	logic [16:0] esec = 17'h0_0000;

	always #25 clk = ~clk;

	hdr_xlate dut_u (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .cell_in, .cell_valid, .cell_ready, .cell_out, .out_valid,
		.out_ready, .translate_n, .tram_addr, .tram_oe_n, .tram_data);
	tram_model mem_u (.tram_addr, .tram_oe_n, .tram_data);

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic at, wt, bt;
		logic [1:0] r;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		bt = 1'b0;
		while (!bt) begin
			@(negedge clk);
			at = awvalid & awready;
			wt = wvalid & wready;
			bt = bvalid;
			r = bresp;
			@(posedge clk);
			if (at) awvalid <= 1'b0;
			if (wt) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk("bresp", RESP_OKAY, r);
	endtask

	task automatic rc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
		logic at, rt;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rt = 1'b0;
		while (!rt) begin
			@(negedge clk);
			at = arvalid & arready;
			rt = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (at) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chk("rdata", e, d);
		chk("rresp", er, r);
	endtask

	task automatic ld(input int a, input logic [47:0] b);
		for (int i = 0; i < 6; i++) begin
			mem_u.mem[a + i] = b[47 - 8 * i -: 8];
		end
	endtask

	// record address for page index 2 of a one-page vpi, user side, no second header
	function automatic int vca(input int s, input int v);
		return 1024 + 2 * ((s == 3) ? 128 : (256 << s)) * 6 + v * 6;
	endfunction

	task automatic xl(input logic [11:0] v, input logic [15:0] c, input logic [2:0] p,
		input logic eg, input logic [11:0] ev, input logic [15:0] ec, input logic [15:0] eb);
		logic g;
		repeat (3) @(posedge clk);
		cell_in <= '{v, c, p, 1'b0};
		cell_valid <= 1'b1;
		do @(negedge clk); while (cell_ready !== 1'b1);
		@(posedge clk);
		cell_valid <= 1'b0;
		g = 1'b0;
		repeat (60) begin
			@(negedge clk);
			if (out_valid === 1'b1 && !g) begin
				g = 1'b1;
				chk("vpi", ev, cell_out.vpi);
				chk("vci", ec, cell_out.vci);
				chk("added", !translate_n, cell_out.hdr_added);
				chk("second", esec, {cell_out.second_en, cell_out.second_hdr});
				if (!translate_n) chk("bus", eb, cell_out.bus_hdr);
			end
		end
		chk("forwarded", eg, g);
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rc(REG_CTRL, 32'h0000_0000, RESP_OKAY);
		rc(4'hC, 32'h0000_0000, RESP_SLVERR);
		xl(12'h012, 16'h0055, 3'h0, 1'b1, 12'h012, 16'h0055, 16'h0000);
		translate_n <= 1'b0;
		wr(REG_CTRL, 32'h0000_0001);
		ld(20, 48'hC345_BEEF_0000);
		xl(12'h005, 16'h0077, 3'h0, 1'b1, 12'h345, 16'h0077, 16'hBEEF);
		xl(12'h007, 16'h0001, 3'h0, 1'b0, 12'h000, 16'h0000, 16'h0000);
		rc(REG_MISS, 32'h0000_0001, RESP_OKAY);
		ld(36, 48'hD011_1234_0000);
		xl(12'h009, 16'h0001, 3'h0, 1'b0, 12'h000, 16'h0000, 16'h0000);
		rc(REG_MISS, 32'h0000_0001, RESP_OKAY);
		wr(REG_CTRL, 32'h0000_0021);
		xl(12'h009, 16'h0001, 3'h0, 1'b1, 12'h011, 16'h0001, 16'h1234);
		ld(44, 48'h8102_0000_0000);
		for (int s = 0; s < 4; s++) begin
			wr(REG_CTRL, 32'h0000_0001 | (s << 3));
			ld(vca(s, 10), {16'h8456, 16'h0123, 8'hC0, 8'(s)});
			xl(12'h00B, 16'h000A, 3'h0, 1'b1, 12'h456, 16'h0123, {8'hC0, 8'(s)});
		end
		ld(vca(3, 128), 48'h8456_0123_C0FF);
		xl(12'h00B, 16'h0080, 3'h0, 1'b0, 12'h000, 16'h0000, 16'h0000);
		rc(REG_MISS, 32'h0000_0002, RESP_OKAY);
		wr(REG_CTRL, 32'h0000_0003);
		ld(52, 48'hA102_0000_0000);
		ld(1042, 48'h8077_0099_ABCD);
		xl(12'h00D, 16'h0003, 3'h0, 1'b1, 12'h077, 16'h0099, 16'hABCD);
		ld(1216, 48'h8088_0066_1221);
		xl(12'h00D, 16'h0006, 3'h6, 1'b1, 12'h088, 16'h0066, 16'h1221);
		ld(1048, 48'hC000_0000_5A5A);
		xl(12'h00D, 16'h0004, 3'h0, 1'b1, 12'h00D, 16'h0004, 16'h5A5A);
		ld(1054, 48'hA000_0000_0000);
		ld(vca(0, 5), 48'h8033_0005_7777);
		xl(12'h00D, 16'h0005, 3'h0, 1'b1, 12'h033, 16'h0005, 16'h7777);
		ld(vca(0, 40), 48'hA021_0028_2A2A);
		xl(12'h00D, 16'h0028, 3'h0, 1'b1, 12'h021, 16'h0028, 16'h2A2A);
		for (int p = 4; p < 8; p++) begin
			ld(1024 + (29 + p) * 6, {16'h8030, 16'h0000, 8'h33, 8'(p)});
			xl(12'h00D, 16'h0028, 3'(p), 1'b1, 12'h030, 16'h0000, {8'h33, 8'(p)});
		end
		wr(REG_CTRL, 32'h0000_0001);
		ld(vca(0, 3), 48'h8044_0003_1111);
		xl(12'h00D, 16'h0003, 3'h0, 1'b1, 12'h044, 16'h0003, 16'h1111);
		// page base 255, second page would be index 256: a live record sits there as bait
		wr(REG_CTRL, 32'h0000_0019);
		ld(60, 48'h82FF_0000_0000);
		ld(1024 + 256 * 128 * 6, 48'h8456_0123_C0FF);
		xl(12'h00F, 16'h0080, 3'h0, 1'b0, 12'h000, 16'h0000, 16'h0000);
		rc(REG_MISS, 32'h0000_0003, RESP_OKAY);
		wr(REG_CTRL, 32'h0000_0005);
		ld(30, 48'hC345_BEEF_CAFE);
		esec = 17'h1_CAFE;
		xl(12'h005, 16'h0077, 3'h0, 1'b1, 12'h345, 16'h0077, 16'hBEEF);
		report_and_stop();
	end

	// bound on the whole run, well above the expected span of the sequence
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		$display("MISMATCH watchdog expected done seen hang");
		report_and_stop();
	end
endmodule
